// >>> hdl/libp_top.sv
// Indicator LED drive: blink pattern gating a brightness PWM.
// Assumes an APB master on the core clock; operating state from the mode logic.
//
// Operation
// - Talk-through pattern 000 keeps LED lit
// - Codes 1-7: 80 ms on, 80 ms times code off
// - Talk-through duty: off, 25, 50, 100 percent
// - PWM period 18 us; quiet duty same encoding
// - Quieting pattern 00 keeps LED lit
// - Quieting codes: 80 ms on, 1/1.5/2.5 s off
// - Fallback select 00 off, 11 always lit
// - Fallback 01 quiet timing, 10 talk timing
// - Fallback lit uses fixed 25 percent duty
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module libp_top
    import libp_pkg::*;
#(
    parameter int MS_CYC = libp_pkg::LIBP_MS_CYC
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Operating state
    input wire libp_pkg::libp_state_t I_OP_STATE,
    // LED current sink
    output logic O_INDICATOR_CURRENT_SINK
);
    import libp_pkg::*;

    // -----------------------------------------------------------------
    // Register file
    // -----------------------------------------------------------------
    logic [7:0] talk_cfg_q, talk_cfg_d;
    logic [7:0] quiet_cfg_q, quiet_cfg_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic ready_q, ready_d;
    logic setup;
    logic hit;
    logic lit;
    logic sink;

    assign setup = I_PSEL && !I_PENABLE;
    assign hit = I_PADDR == LIBP_TALK_CFG_ADDR || I_PADDR == LIBP_QUIET_CFG_ADDR ||
        I_PADDR == LIBP_STATE_ADDR;

    // No wait state: answer is registered in setup, ready in the first access cycle
    always_comb begin
        talk_cfg_d = talk_cfg_q;
        quiet_cfg_d = quiet_cfg_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        ready_d = setup;
        if (setup) begin
            err_d = !hit;
            rdata_d = 32'h0000_0000;
            if (!I_PWRITE) begin
                unique case (I_PADDR)
                    LIBP_TALK_CFG_ADDR: rdata_d = {24'h00_0000, talk_cfg_q};
                    LIBP_QUIET_CFG_ADDR: rdata_d = {24'h00_0000, quiet_cfg_q};
                    LIBP_STATE_ADDR: rdata_d = {29'h0000_0000, sink, I_OP_STATE};
                    default: rdata_d = 32'h0000_0000;
                endcase
            end
        end
        if (I_PSEL && I_PENABLE && ready_q && I_PWRITE) begin
            if (I_PADDR == LIBP_TALK_CFG_ADDR) begin
                talk_cfg_d = I_PWDATA[7:0] & LIBP_TALK_CFG_MASK;
            end
            if (I_PADDR == LIBP_QUIET_CFG_ADDR) begin
                quiet_cfg_d = I_PWDATA[7:0] & LIBP_QUIET_CFG_MASK;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            talk_cfg_q <= LIBP_TALK_CFG_RST;
            quiet_cfg_q <= LIBP_QUIET_CFG_RST;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            talk_cfg_q <= talk_cfg_d;
            quiet_cfg_q <= quiet_cfg_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            ready_q <= ready_d;
        end
    end

    assign O_PRDATA = rdata_q;
    assign O_PREADY = ready_q;
    assign O_PSLVERR = ready_q && err_q;

    // -----------------------------------------------------------------
    // Pattern selection
    // -----------------------------------------------------------------
    logic [2:0] talk_pat;
    logic [1:0] quiet_pat;
    libp_fb_t fb_sel;
    libp_duty_t talk_duty, quiet_duty, duty;
    logic [11:0] talk_off_ms, quiet_off_ms, off_ms;
    logic blink_en;
    libp_state_t state_q;
    logic restart;

    assign talk_pat = talk_cfg_q[LIBP_TALK_PAT_LSB +: 3];
    assign talk_duty = libp_duty_t'(talk_cfg_q[LIBP_TALK_DUTY_LSB +: 2]);
    assign quiet_pat = quiet_cfg_q[LIBP_QUIET_PAT_LSB +: 2];
    assign quiet_duty = libp_duty_t'(quiet_cfg_q[LIBP_QUIET_DUTY_LSB +: 2]);
    assign fb_sel = libp_fb_t'(quiet_cfg_q[LIBP_FALL_SEL_LSB +: 2]);
    // Off time is a multiple of the on time; zero means steady
    assign talk_off_ms = 12'(LIBP_BLINK_ON_MS) * {9'h000, talk_pat};

    always_comb begin
        unique case (quiet_pat)
            2'b00: quiet_off_ms = 12'h000;
            2'b01: quiet_off_ms = 12'(LIBP_Q1_OFF_MS);
            2'b10: quiet_off_ms = 12'(LIBP_Q2_OFF_MS);
            2'b11: quiet_off_ms = 12'(LIBP_Q3_OFF_MS);
        endcase
    end

    always_comb begin
        off_ms = 12'h000;
        blink_en = 1'b0;
        duty = LIBP_DUTY_OFF;
        unique case (I_OP_STATE)
            LIBP_ST_IDLE: begin
                blink_en = 1'b0;
            end
            LIBP_ST_TALK: begin
                blink_en = 1'b1;
                off_ms = talk_off_ms;
                duty = talk_duty;
            end
            LIBP_ST_QUIET: begin
                blink_en = 1'b1;
                off_ms = quiet_off_ms;
                duty = quiet_duty;
            end
            LIBP_ST_FALL: begin
                duty = LIBP_DUTY_25;
                unique case (fb_sel)
                    LIBP_FB_OFF: blink_en = 1'b0;
                    LIBP_FB_QUIET: begin
                        blink_en = 1'b1;
                        off_ms = quiet_off_ms;
                    end
                    LIBP_FB_TALK: begin
                        blink_en = 1'b1;
                        off_ms = talk_off_ms;
                    end
                    LIBP_FB_ON: blink_en = 1'b1;
                endcase
            end
        endcase
    end

    // -----------------------------------------------------------------
    // State change detect
    // -----------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_q <= LIBP_ST_IDLE;
        end else begin
            state_q <= I_OP_STATE;
        end
    end

    assign restart = I_OP_STATE != state_q;

    // -----------------------------------------------------------------
    // Timers and output
    // -----------------------------------------------------------------
    libp_blink #(
        .MS_CYC(MS_CYC)
    ) u_blink (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_restart(restart),
        .i_off_ms(off_ms),
        .o_lit(lit)
    );

    libp_pwm u_pwm (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_duty(duty),
        .i_restart(restart),
        .o_pwm(sink)
    );

    logic gate_q, gate_d;

    // Gate registered so sink and gate line up with the PWM flop
    assign gate_d = blink_en && lit;
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            gate_q <= 1'b0;
        end else begin
            gate_q <= gate_d;
        end
    end

    assign O_INDICATOR_CURRENT_SINK = gate_q && sink;

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    sequence fb_off_s;
        I_OP_STATE == LIBP_ST_FALL && fb_sel == LIBP_FB_OFF;
    endsequence

    sequence fb_on_s;
        I_OP_STATE == LIBP_ST_FALL && fb_sel == LIBP_FB_ON;
    endsequence

    sequence talk_steady_s;
        I_OP_STATE == LIBP_ST_TALK && talk_pat == 3'b000;
    endsequence

    // Gate lags the pattern by two cycles (blink flop, then gate flop), so a steady pattern is held two cycles
    sequence quiet_steady_s;
        I_OP_STATE == LIBP_ST_QUIET && quiet_pat == 2'b00;
    endsequence

    fallback_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        fb_off_s ##1 fb_off_s |-> !O_INDICATOR_CURRENT_SINK)
        else $error("Fallback off lit LED");
    fallback_on_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        fb_on_s ##1 fb_on_s |=> gate_q) else $error("Fallback on went dark");
    fallback_duty_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_OP_STATE == LIBP_ST_FALL |-> duty == LIBP_DUTY_25)
        else $error("Fallback duty not quarter");
    talk_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_OP_STATE == LIBP_ST_TALK && talk_duty == LIBP_DUTY_OFF ##1
        I_OP_STATE == LIBP_ST_TALK && talk_duty == LIBP_DUTY_OFF |=>
        !O_INDICATOR_CURRENT_SINK) else $error("Sink on at duty off");
    talk_steady_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        talk_steady_s ##1 talk_steady_s |=> gate_q) else $error("Talk steady went dark");
    quiet_steady_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        quiet_steady_s ##1 quiet_steady_s |=> gate_q)
        else $error("Quiet steady went dark");
    quiet_off_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_OP_STATE == LIBP_ST_QUIET && quiet_pat == 2'b11 |->
        off_ms == 12'(LIBP_Q3_OFF_MS)) else $error("Quiet off time wrong");
    full_on_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        $stable(I_OP_STATE) && gate_q && duty == LIBP_DUTY_FULL && $stable(duty)
        |-> O_INDICATOR_CURRENT_SINK) else $error("Full duty not lit");
    state_restart_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        restart |=> u_blink.ms_q == '0) else $error("No restart on state change");
    apb_wait_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        setup |=> O_PREADY) else $error("APB answer late");
    cfg_write_a: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
        I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == LIBP_TALK_CFG_ADDR
        |=> talk_cfg_q == (8'($past(I_PWDATA)) & LIBP_TALK_CFG_MASK))
        else $error("Config write lost");
endmodule
`default_nettype wire

// >>> hdl/libp_pkg.sv
// Constants for the indicator LED blink and brightness PWM block.
// Assumes a 25 MHz core clock and an APB register slave.
package libp_pkg;

    // -----------------------------------------------------------------
    // Register map
    // -----------------------------------------------------------------
    localparam logic [7:0] LIBP_TALK_CFG_IDX = 8'h08;
    localparam logic [7:0] LIBP_QUIET_CFG_IDX = 8'h09;
    localparam logic [7:0] LIBP_STATE_IDX = 8'h10;
    localparam logic [11:0] LIBP_TALK_CFG_ADDR = {2'b00, LIBP_TALK_CFG_IDX, 2'b00};
    localparam logic [11:0] LIBP_QUIET_CFG_ADDR = {2'b00, LIBP_QUIET_CFG_IDX, 2'b00};
    localparam logic [11:0] LIBP_STATE_ADDR = {2'b00, LIBP_STATE_IDX, 2'b00};
    localparam logic [7:0] LIBP_TALK_CFG_RST = 8'h00;
    localparam logic [7:0] LIBP_QUIET_CFG_RST = 8'h00;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int LIBP_TALK_PAT_LSB = 2;
    localparam int LIBP_TALK_DUTY_LSB = 0;
    localparam int LIBP_FALL_SEL_LSB = 5;
    localparam int LIBP_QUIET_PAT_LSB = 2;
    localparam int LIBP_QUIET_DUTY_LSB = 0;
    localparam logic [7:0] LIBP_TALK_CFG_MASK = 8'h1F;
    localparam logic [7:0] LIBP_QUIET_CFG_MASK = 8'h6F;

    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int LIBP_CLK_KHZ = 25_000;
    localparam int LIBP_PWM_PERIOD_US = 18;
    localparam int LIBP_ON25_US = 4;
    localparam int LIBP_ON50_US = 9;
    localparam int LIBP_PWM_PERIOD_CYC = LIBP_PWM_PERIOD_US * LIBP_CLK_KHZ / 1000;
    localparam int LIBP_ON25_CYC = LIBP_ON25_US * LIBP_CLK_KHZ / 1000;
    localparam int LIBP_ON50_CYC = LIBP_ON50_US * LIBP_CLK_KHZ / 1000;
    localparam int LIBP_BLINK_ON_MS = 80;
    localparam int LIBP_Q1_OFF_MS = 1000;
    localparam int LIBP_Q2_OFF_MS = 1500;
    localparam int LIBP_Q3_OFF_MS = 2500;
    localparam int LIBP_MS_CYC = LIBP_CLK_KHZ;

    // -----------------------------------------------------------------
    // Encodings
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        LIBP_DUTY_OFF = 2'b00,
        LIBP_DUTY_25 = 2'b01,
        LIBP_DUTY_50 = 2'b10,
        LIBP_DUTY_FULL = 2'b11
    } libp_duty_t;

    typedef enum logic [1:0] {
        LIBP_ST_IDLE = 2'b00,
        LIBP_ST_TALK = 2'b01,
        LIBP_ST_QUIET = 2'b10,
        LIBP_ST_FALL = 2'b11
    } libp_state_t;

    typedef enum logic [1:0] {
        LIBP_FB_OFF = 2'b00,
        LIBP_FB_QUIET = 2'b01,
        LIBP_FB_TALK = 2'b10,
        LIBP_FB_ON = 2'b11
    } libp_fb_t;

endpackage

// >>> hdl/libp_pwm.sv
// Brightness PWM: fixed period, four duty levels.
// Assumes restart is a one-cycle pulse from the state change detect in the top level.
`timescale 1ns/1ps
`default_nettype none
module libp_pwm
    import libp_pkg::*;
#(
    parameter int PERIOD_CYC = LIBP_PWM_PERIOD_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control
    input wire libp_pkg::libp_duty_t i_duty,
    input wire logic i_restart,
    // Output
    output logic o_pwm
);
    import libp_pkg::*;

    localparam int CW = $clog2(PERIOD_CYC);
    localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
    localparam logic [CW-1:0] ON25 = CW'(LIBP_ON25_CYC);
    localparam logic [CW-1:0] ON50 = CW'(LIBP_ON50_CYC);

    logic [CW-1:0] cnt_q, cnt_d;
    logic pwm_q, pwm_d;

    always_comb begin
        cnt_d = (i_restart || cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        unique case (i_duty)
            LIBP_DUTY_OFF: pwm_d = 1'b0;
            LIBP_DUTY_25: pwm_d = cnt_d < ON25;
            LIBP_DUTY_50: pwm_d = cnt_d < ON50;
            LIBP_DUTY_FULL: pwm_d = 1'b1;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_q <= '0;
            pwm_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pwm_q <= pwm_d;
        end
    end

    assign o_pwm = pwm_q;

    period_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        cnt_q == LAST |=> cnt_q == '0) else $error("PWM period wrong");
    quarter_duty_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (i_duty == LIBP_DUTY_25 && !i_restart && $stable(i_duty)) |=>
        pwm_q == (cnt_q < ON25)) else $error("25 percent duty wrong");
endmodule
`default_nettype wire

// >>> hdl/libp_blink.sv
// Blink timer: on for an interval, off for another, repeated.
// Zero off time means steady on; restart begins a fresh on phase.
`timescale 1ns/1ps
`default_nettype none
module libp_blink
    import libp_pkg::*;
#(
    parameter int MS_CYC = LIBP_MS_CYC
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_restart,
    input wire logic [11:0] i_off_ms,
    // Output
    output logic o_lit
);
    import libp_pkg::*;

    localparam int PW = $clog2(MS_CYC);
    localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYC - 1);
    localparam logic [11:0] ON_MS = 12'(LIBP_BLINK_ON_MS);

    logic [PW-1:0] pre_q, pre_d;
    logic [11:0] ms_q, ms_d;
    logic off_q, off_d;

    always_comb begin
        pre_d = pre_q + 1'b1;
        ms_d = ms_q;
        off_d = off_q;
        if (i_restart || i_off_ms == 12'h000) begin
            pre_d = '0;
            ms_d = '0;
            off_d = 1'b0;
        end else if (pre_q == PRE_LAST) begin
            pre_d = '0;
            ms_d = ms_q + 1'b1;
            if (!off_q && ms_q == ON_MS - 1'b1) begin
                ms_d = '0;
                off_d = 1'b1;
            end else if (off_q && ms_q >= i_off_ms - 1'b1) begin
                ms_d = '0;
                off_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_q <= '0;
            ms_q <= '0;
            off_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            ms_q <= ms_d;
            off_q <= off_d;
        end
    end

    assign o_lit = !off_q;

    steady_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        i_off_ms == 12'h000 |=> o_lit) else $error("Steady pattern went dark");
    on_phase_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        $rose(off_q) |-> $past(ms_q) == ON_MS - 1'b1) else $error("On time wrong");
endmodule
`default_nettype wire

// >>> verification/libp_led_model.sv
// LED model at the indicator sink: counts the cycles in which the sink draws current.
// Assumes the bench pulses the clear input to start each measurement window.
`timescale 1ns/1ps
`default_nettype none
module libp_led_model (
    // Clock
    input wire logic i_clk,
    // Sink and control
    input wire logic i_sink,
    input wire logic i_clear,
    // Measurement
    output logic [31:0] o_lit_cnt
);
    // Integrating lit time over whole periods is phase independent
    always_ff @(posedge i_clk) begin
        if (i_clear) begin
            o_lit_cnt <= 32'h0000_0000;
        end else if (i_sink) begin
            o_lit_cnt <= o_lit_cnt + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

// >>> verification/test_led_indicator_blink_pwm.sv
// Self-checking bench for the indicator LED block: APB master, LED model, lit-time checks.
// Assumes the blink millisecond is shortened to MS cycles through MS_CYC.
`timescale 1ns/1ps
`default_nettype none
module test_led_indicator_blink_pwm;
    import libp_pkg::*;
    localparam int MS = 10;
    localparam int ON = 80 * MS;
    logic clk, rst_b, psel, penable, pwrite, clear, er, sink;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, lit_cnt, seed, v;
    logic pready, pslverr;
    libp_state_t op_state;
    int n_mismatch, samples_checked, fb_exp;

    always #20 clk = ~clk;

    libp_top #(.MS_CYC(MS)) libp_top_i (.I_CLK(clk), .I_RST_B(rst_b), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OP_STATE(op_state),
        .O_INDICATOR_CURRENT_SINK(sink));
    libp_led_model libp_led_model_i (.i_clk(clk), .i_sink(sink), .i_clear(clear),
        .o_lit_cnt(lit_cnt));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function int duty_on(input int d);
        case (d)
            1: return LIBP_ON25_CYC;
            2: return LIBP_ON50_CYC;
            3: return LIBP_PWM_PERIOD_CYC;
            default: return 0;
        endcase
    endfunction

    function int quiet_off(input int q);
        case (q)
            1: return LIBP_Q1_OFF_MS * MS;
            2: return LIBP_Q2_OFF_MS * MS;
            default: return LIBP_Q3_OFF_MS * MS;
        endcase
    endfunction

    task end_of_test();
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task fail(input string m);
        n_mismatch++;
        $display("CHECK FAILED at %0t: %s", $time, m);
    endtask

    task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) fail(m);
    endtask

    task cmp_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi,
                 input string m);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) fail(m);
    endtask

    // Request held until pready is sampled high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        logic got;
        got = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20 && !got; i++) begin
            @(posedge clk);
            if (pready === 1'b1) begin
                got = 1'b1;
                rd = prdata;
                er = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!got) begin
            fail("bus answer missing");
            end_of_test();
        end
    endtask

    task measure(input int n);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Passing through idle forces a fresh blink cycle
    task go(input libp_state_t s);
        @(posedge clk);
        op_state <= LIBP_ST_IDLE;
        repeat (4) @(posedge clk);
        op_state <= s;
    endtask

    initial begin
        repeat (99000) @(posedge clk);
        fail("run did not finish");
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        clear = 1'b0;
        op_state = LIBP_ST_IDLE;
        seed = 32'd86032;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, LIBP_TALK_CFG_ADDR, 32'h0000_0000);
        cmp(rd, {24'h00_0000, LIBP_TALK_CFG_RST}, "talk cfg reset");
        cmp({31'h0, er}, 32'h0000_0000, "mapped read error");
        apb(1'b0, LIBP_QUIET_CFG_ADDR, 32'h0000_0000);
        cmp(rd, {24'h00_0000, LIBP_QUIET_CFG_RST}, "quiet cfg reset");
        for (int k = 0; k < 4; k++) begin
            v = rnd();
            apb(1'b1, LIBP_TALK_CFG_ADDR, v);
            apb(1'b0, LIBP_TALK_CFG_ADDR, 32'h0000_0000);
            cmp(rd, {24'h00_0000, v[7:0] & LIBP_TALK_CFG_MASK}, "talk cfg readback");
            v = rnd();
            apb(1'b1, LIBP_QUIET_CFG_ADDR, v);
            apb(1'b0, LIBP_QUIET_CFG_ADDR, 32'h0000_0000);
            cmp(rd, {24'h00_0000, v[7:0] & LIBP_QUIET_CFG_MASK}, "quiet cfg readback");
        end
        apb(1'b1, 12'h0FC, rnd());
        cmp({31'h0, er}, 32'h0000_0001, "unmapped write error");
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        cmp(rd, 32'h0000_0000, "unmapped read data");
        cmp({31'h0, er}, 32'h0000_0001, "unmapped read error");
        // Mid-run reset returns both configs to their defaults
        apb(1'b1, LIBP_TALK_CFG_ADDR, 32'h0000_001F);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, LIBP_TALK_CFG_ADDR, 32'h0000_0000);
        cmp(rd, {24'h00_0000, LIBP_TALK_CFG_RST}, "talk cfg after reset");
        apb(1'b0, LIBP_QUIET_CFG_ADDR, 32'h0000_0000);
        cmp(rd, {24'h00_0000, LIBP_QUIET_CFG_RST}, "quiet cfg after reset");
        measure(900);
        cmp(lit_cnt, 32'h0000_0000, "idle led lit");
        // Duty levels with steady talk-through pattern
        @(posedge clk);
        op_state <= LIBP_ST_TALK;
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, LIBP_TALK_CFG_ADDR, 32'(d));
            repeat (20) @(posedge clk);
            measure(2 * LIBP_PWM_PERIOD_CYC);
            cmp(lit_cnt, 32'(2 * duty_on(d)), "talk duty lit time");
        end
        apb(1'b0, LIBP_STATE_ADDR, 32'h0000_0000);
        cmp(rd, 32'h0000_0005, "status state and raw PWM");
        // Blink codes: one period plus a second on phase
        for (int c = 1; c < 8; c++) begin
            apb(1'b1, LIBP_TALK_CFG_ADDR, 32'((c << LIBP_TALK_PAT_LSB) | 3));
            go(LIBP_ST_TALK);
            measure(2 * ON + c * ON);
            cmp_rng(lit_cnt, 32'(2 * ON - 8), 32'(2 * ON + 8), "talk blink");
        end
        for (int d = 0; d < 4; d++) begin
            apb(1'b1, LIBP_QUIET_CFG_ADDR, 32'(d));
            go(LIBP_ST_QUIET);
            repeat (20) @(posedge clk);
            measure(2 * LIBP_PWM_PERIOD_CYC);
            cmp(lit_cnt, 32'(2 * duty_on(d)), "quiet duty lit time");
        end
        v = 32'(1 + rnd() % 3);
        apb(1'b1, LIBP_QUIET_CFG_ADDR, 32'((v << LIBP_QUIET_PAT_LSB) | 3));
        go(LIBP_ST_QUIET);
        measure(2 * ON + quiet_off(int'(v)));
        cmp_rng(lit_cnt, 32'(2 * ON - 8), 32'(2 * ON + 8), "quiet blink");
        // Fallback: full duty configured, fixed quarter duty expected
        apb(1'b1, LIBP_QUIET_CFG_ADDR, 32'h0000_0003);
        go(LIBP_ST_FALL);
        measure(2 * LIBP_PWM_PERIOD_CYC);
        cmp(lit_cnt, 32'h0000_0000, "fallback off");
        apb(1'b1, LIBP_QUIET_CFG_ADDR, 32'h0000_0063);
        repeat (20) @(posedge clk);
        measure(2 * LIBP_PWM_PERIOD_CYC);
        cmp(lit_cnt, 32'(2 * LIBP_ON25_CYC), "fallback steady");
        fb_exp = 2 * ON * LIBP_ON25_CYC / LIBP_PWM_PERIOD_CYC;
        apb(1'b1, LIBP_TALK_CFG_ADDR, 32'h0000_000B);
        apb(1'b1, LIBP_QUIET_CFG_ADDR, 32'h0000_0043);
        go(LIBP_ST_FALL);
        measure(4 * ON);
        cmp_rng(lit_cnt, 32'(fb_exp - 120), 32'(fb_exp + 120), "fallback talk timing");
        apb(1'b1, LIBP_QUIET_CFG_ADDR, 32'h0000_0027);
        go(LIBP_ST_FALL);
        measure(2 * ON + quiet_off(1));
        cmp_rng(lit_cnt, 32'(fb_exp - 120), 32'(fb_exp + 120), "fallback quiet timing");
        end_of_test();
    end
endmodule
`default_nettype wire
